/* File: inc/map_pkg.sv */
package map_pkg;

   // ----------------------------------------
   // Register indices; byte address is four times the index.
   // ----------------------------------------
   localparam logic [5:0] IDX_MODE_CTL = 6'h0b;
   localparam logic [5:0] IDX_RAM_POS = 6'h10;
   localparam logic [5:0] IDX_REG_POS = 6'h11;
   localparam logic [5:0] IDX_EE_POS = 6'h12;

   // ----------------------------------------
   // Field positions.
   // ----------------------------------------
   localparam int BIT_EXT_WAIT_STOP = 2;
   localparam int BIT_K_EMULATE = 1;
   localparam int BIT_E_EMULATE = 0;
   localparam int BIT_MAP_WAIT_STOP = 0;
   localparam int BIT_EE_ON = 0;

   // ----------------------------------------
   // Reset values.
   // ----------------------------------------
   localparam logic [4:0] RST_REG_POS = 5'h00;
   localparam logic [2:0] RST_RAM_POS = 3'h1;
   localparam logic [3:0] RST_EE_POS = 4'h0;
   localparam logic RST_EE_ON = 1'b1;

   // ----------------------------------------
   // Port register offsets inside the register block.
   // ----------------------------------------
   localparam logic [9:0] OFF_E_DATA = 10'h008;
   localparam logic [9:0] OFF_E_DIR = 10'h009;
   localparam logic [9:0] OFF_K_DATA = 10'h0fd;
   localparam logic [9:0] OFF_K_DIR = 10'h0ff;

   // ----------------------------------------
   // Fixed address areas.
   // ----------------------------------------
   localparam logic [7:0] DEBUG_ROM_PAGE = 8'hff;
   localparam logic [1:0] FLASH_FIXED_LOW = 2'h1;
   localparam logic [1:0] FLASH_WINDOW = 2'h2;
   localparam logic [1:0] FLASH_FIXED_HIGH = 2'h3;
   localparam logic [1:0] FIXED_ARRAY = 2'h3;

   // ----------------------------------------
   // Timing.
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int EXT_STOP_DELAY_NS = 40;
   localparam int EXT_STOP_CYCLES = (EXT_STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] EXT_STOP_COUNT = 3'(EXT_STOP_CYCLES);

endpackage : map_pkg

/* File: src/resource_map_decoder.sv */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps

module resource_map_decoder
   import map_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM register slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Operating mode.
   input wire logic special_mode_select_n,
   input wire logic mode_b,
   input wire logic mode_a,
   input wire logic wait_mode,
   input wire logic ext_bus_busy,
   input wire logic debug_rom_active,
   // CPU address to decode.
   input wire logic [15:0] cpu_addr,
   input wire logic [2:0] flash_page,
   // Decode results.
   output logic sel_debug_rom,
   output logic sel_regs,
   output logic sel_ram,
   output logic sel_eeprom,
   output logic sel_flash,
   output logic sel_external,
   output logic [1:0] flash_array,
   output logic [14:0] flash_offset,
   output logic k_port_mapped,
   output logic e_port_mapped,
   output logic k_port_gpio,
   // Wait-mode shutdown.
   output logic ext_bus_shutdown,
   output logic map_if_shutdown
);
   import map_pkg::*;

   // ----------------------------------------
   // State.
   // ----------------------------------------
   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic ext_bus_wait_stop;
      logic k_port_emulate;
      logic e_port_emulate;
      logic map_if_wait_stop;
      logic k_wr_seen;
      logic e_wr_seen;
      logic rg_wr_seen;
      logic rm_wr_seen;
      logic ee_wr_seen;
      logic [4:0] register_block_position;
      logic [2:0] ram_position;
      logic [3:0] eeprom_position;
      logic ee_on;
      logic [4:0] rg_act;
      logic [2:0] rm_act;
      logic [3:0] ee_act;
      logic ee_on_act;
      logic [2:0] stop_cnt;
      logic bus_off;
   } st_s;

   st_s s_q;
   st_s s_d;

   logic special;
   logic single_chip;
   logic peripheral;
   logic expanded;
   logic [5:0] idx;
   logic bus_req;
   logic wr_ok;
   logic in_reg_blk;
   logic reg_hole;
   logic [9:0] reg_off;
   logic hit_dbg;
   logic hit_ram;
   logic hit_ee;
   logic hit_flash;

   // ----------------------------------------
   // Mode decode.
   // ----------------------------------------
   assign special = ~special_mode_select_n;
   assign single_chip = ~mode_b & ~mode_a;
   assign peripheral = special & mode_b & ~mode_a;
   assign expanded = ~single_chip & ~peripheral;
   assign idx = avs_address[7:2];
   assign bus_req = avs_read | avs_write;
   assign wr_ok = avs_write & s_q.ack & avs_byteenable[0];

   // One wait state per access; the answer edge is the one where ack is high.
   assign avs_waitrequest = bus_req & ~s_q.ack;
   assign avs_readdata = {24'h000000, s_q.rdata};

   // ----------------------------------------
   // Port register visibility.
   // ----------------------------------------
   assign k_port_mapped = single_chip | ~s_q.k_port_emulate;
   assign e_port_mapped = ~expanded | ~s_q.e_port_emulate;
   // Without emulation the port K pins fall back to plain I/O.
   assign k_port_gpio = ~s_q.k_port_emulate | single_chip;

   // ----------------------------------------
   // Address decode with fixed precedence.
   // ----------------------------------------
   assign reg_off = cpu_addr[9:0];
   assign in_reg_blk = (cpu_addr[15:11] == s_q.rg_act) & ~cpu_addr[10];
   // Removed port registers fall through so external logic can emulate them.
   assign reg_hole = (~k_port_mapped & ((reg_off == OFF_K_DATA) | (reg_off == OFF_K_DIR)))
                   | (~e_port_mapped & ((reg_off == OFF_E_DATA) | (reg_off == OFF_E_DIR)));
   assign hit_dbg = debug_rom_active & (cpu_addr[15:8] == DEBUG_ROM_PAGE);
   assign hit_ram = cpu_addr[15:13] == s_q.rm_act;
   assign hit_ee = s_q.ee_on_act & (cpu_addr[15:12] == s_q.ee_act) & cpu_addr[11];
   assign hit_flash = cpu_addr[15:14] != 2'h0;

   // Each select is masked by every higher one, so exactly one is ever high.
   always_comb begin
      sel_debug_rom = hit_dbg;
      sel_regs = ~hit_dbg & in_reg_blk & ~reg_hole;
      sel_ram = ~hit_dbg & ~sel_regs & hit_ram;
      sel_eeprom = ~hit_dbg & ~sel_regs & ~hit_ram & hit_ee;
      sel_flash = ~hit_dbg & ~sel_regs & ~hit_ram & ~hit_ee & hit_flash;
      sel_external = ~hit_dbg & ~sel_regs & ~hit_ram & ~hit_ee & ~hit_flash;
   end

   // Fixed array sits at both 16K ranges; the window takes the page input.
   always_comb begin
      case (cpu_addr[15:14])
         FLASH_FIXED_LOW: begin
            flash_array = FIXED_ARRAY;
            flash_offset = {1'b0, cpu_addr[13:0]};
         end
         FLASH_WINDOW: begin
            flash_array = flash_page[2:1];
            flash_offset = {flash_page[0], cpu_addr[13:0]};
         end
         FLASH_FIXED_HIGH: begin
            flash_array = FIXED_ARRAY;
            flash_offset = {1'b1, cpu_addr[13:0]};
         end
         default: begin
            flash_array = 2'h0;
            flash_offset = 15'h0000;
         end
      endcase
   end

   assign ext_bus_shutdown = s_q.bus_off;
   assign map_if_shutdown = wait_mode & s_q.map_if_wait_stop;

   // ----------------------------------------
   // Next state.
   // ----------------------------------------
   // Emulate bits come out of reset set in special modes, clear in normal ones.
   always_comb begin
      s_d = s_q;
      if (rst) begin
         s_d = '0;
         s_d.k_port_emulate = special;
         s_d.e_port_emulate = special;
         s_d.register_block_position = RST_REG_POS;
         s_d.ram_position = RST_RAM_POS;
         s_d.eeprom_position = RST_EE_POS;
         s_d.ee_on = RST_EE_ON;
         s_d.rg_act = RST_REG_POS;
         s_d.rm_act = RST_RAM_POS;
         s_d.ee_act = RST_EE_POS;
         s_d.ee_on_act = RST_EE_ON;
      end else begin
         s_d.ack = bus_req & ~s_q.ack;
         // Read data is loaded during the wait cycle and stands at the answer edge.
         if (avs_read & ~s_q.ack) begin
            case (idx)
               IDX_MODE_CTL: s_d.rdata = {special_mode_select_n, mode_b, mode_a, 2'b00,
                                          s_q.ext_bus_wait_stop, s_q.k_port_emulate, s_q.e_port_emulate};
               IDX_RAM_POS: s_d.rdata = {s_q.ram_position, 5'h00};
               IDX_REG_POS: s_d.rdata = {s_q.register_block_position, 2'b00, s_q.map_if_wait_stop};
               IDX_EE_POS: s_d.rdata = {s_q.eeprom_position, 3'h0, s_q.ee_on};
               default: s_d.rdata = 8'h00;
            endcase
         end
         if (wr_ok) begin
            case (idx)
               IDX_MODE_CTL: begin
                  if (!special) begin
                     s_d.ext_bus_wait_stop = avs_writedata[BIT_EXT_WAIT_STOP];
                  end
                  // First write is only recorded in special modes, taken in normal ones.
                  s_d.k_wr_seen = 1'b1;
                  s_d.e_wr_seen = 1'b1;
                  if (special == s_q.k_wr_seen) begin
                     s_d.k_port_emulate = avs_writedata[BIT_K_EMULATE];
                  end
                  if (special == s_q.e_wr_seen) begin
                     s_d.e_port_emulate = avs_writedata[BIT_E_EMULATE];
                  end
               end
               IDX_RAM_POS: begin
                  s_d.rm_wr_seen = 1'b1;
                  if (special | ~s_q.rm_wr_seen) begin
                     s_d.ram_position = avs_writedata[7:5];
                  end
               end
               IDX_REG_POS: begin
                  s_d.rg_wr_seen = 1'b1;
                  if (special | ~s_q.rg_wr_seen) begin
                     s_d.register_block_position = avs_writedata[7:3];
                  end
                  if (!special) begin
                     s_d.map_if_wait_stop = avs_writedata[BIT_MAP_WAIT_STOP];
                  end
               end
               IDX_EE_POS: begin
                  s_d.ee_wr_seen = 1'b1;
                  if (special | ~s_q.ee_wr_seen) begin
                     s_d.eeprom_position = avs_writedata[7:4];
                     s_d.ee_on = avs_writedata[BIT_EE_ON];
                  end
               end
               default: begin
               end
            endcase
         end
         // The decode follows the stored positions one cycle late.
         s_d.rg_act = s_q.register_block_position;
         s_d.rm_act = s_q.ram_position;
         s_d.ee_act = s_q.eeprom_position;
         s_d.ee_on_act = s_q.ee_on | single_chip;
         // Shutdown waits for idle bus cycles so a last transfer can finish.
         if (wait_mode & s_q.ext_bus_wait_stop) begin
            if (ext_bus_busy) begin
               s_d.stop_cnt = 3'h0;
            end else if (s_q.stop_cnt != EXT_STOP_COUNT) begin
               s_d.stop_cnt = s_q.stop_cnt + 3'h1;
            end
            s_d.bus_off = s_q.bus_off | (s_q.stop_cnt == EXT_STOP_COUNT);
         end else begin
            s_d.stop_cnt = 3'h0;
            s_d.bus_off = 1'b0;
         end
      end
   end

   // Single state register.
   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // ----------------------------------------
   // Assertions.
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_wait_stop_held;
      (wait_mode & s_q.ext_bus_wait_stop & ~ext_bus_busy) [*5];
   endsequence

   sequence s_bus_stays_up;
      ~ext_bus_shutdown [*5];
   endsequence

   property p_ext_stop_delay;
      s_wait_stop_held |=> ext_bus_shutdown;
   endproperty
   a_ext_stop_delay: assert property (p_ext_stop_delay) else $error("external bus not shut down");

   property p_ext_stop_not_early;
      $rose(wait_mode & s_q.ext_bus_wait_stop) && !ext_bus_busy && !$past(ext_bus_shutdown)
         |-> s_bus_stays_up;
   endproperty
   a_ext_stop_not_early: assert property (p_ext_stop_not_early) else $error("external bus shut too early");

   property p_ext_bus_runs;
      !(wait_mode & s_q.ext_bus_wait_stop) |=> !ext_bus_shutdown;
   endproperty
   a_ext_bus_runs: assert property (p_ext_bus_runs) else $error("external bus stopped while allowed");

   property p_wait_stop_locked;
      special && !$past(rst) |=> $stable(s_q.ext_bus_wait_stop) && $stable(s_q.map_if_wait_stop);
   endproperty
   a_wait_stop_locked: assert property (p_wait_stop_locked) else $error("wait-stop changed in special mode");

   property p_single_chip_mapped;
      single_chip |-> k_port_mapped && e_port_mapped;
   endproperty
   a_single_chip_mapped: assert property (p_single_chip_mapped) else $error("port unmapped in single chip");

   property p_port_hole;
      ~single_chip && s_q.k_port_emulate && in_reg_blk && (reg_off == OFF_K_DATA) |-> !sel_regs;
   endproperty
   a_port_hole: assert property (p_port_hole) else $error("emulated port K still decoded");

   property p_e_port_map;
      expanded && in_reg_blk && !hit_dbg && (reg_off == OFF_E_DIR) |-> sel_regs == !s_q.e_port_emulate;
   endproperty
   a_e_port_map: assert property (p_e_port_map) else $error("port E mapping wrong");

   property p_emulate_once;
      !special && s_q.k_wr_seen |=> $stable(s_q.k_port_emulate);
   endproperty
   a_emulate_once: assert property (p_emulate_once) else $error("emulate bit rewritten in normal mode");

   property p_position_once;
      !special && s_q.rg_wr_seen |=> $stable(s_q.register_block_position);
   endproperty
   a_position_once: assert property (p_position_once) else $error("position rewritten in normal mode");

   property p_position_lag;
      wr_ok && (idx == IDX_REG_POS) && (special || !s_q.rg_wr_seen)
         |=> (s_q.rg_act == $past(s_q.rg_act)) ##1 (s_q.rg_act == $past(avs_writedata[7:3], 2));
   endproperty
   a_position_lag: assert property (p_position_lag) else $error("position not applied one cycle late");

   property p_one_hot;
      $onehot({sel_debug_rom, sel_regs, sel_ram, sel_eeprom, sel_flash, sel_external});
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("decode not one-hot");

   property p_regs_over_ram;
      hit_ram && in_reg_blk && !reg_hole && !hit_dbg |-> sel_regs && !sel_ram;
   endproperty
   a_regs_over_ram: assert property (p_regs_over_ram) else $error("RAM won over registers");

   property p_fixed_flash;
      sel_flash && cpu_addr[14] |-> flash_array == FIXED_ARRAY && flash_offset[14] == cpu_addr[15];
   endproperty
   a_fixed_flash: assert property (p_fixed_flash) else $error("fixed flash range misdecoded");

   property p_upper_half_falls;
      (cpu_addr[15:11] == s_q.rg_act) && cpu_addr[10] |-> !sel_regs;
   endproperty
   a_upper_half_falls: assert property (p_upper_half_falls) else $error("upper 1K decoded as registers");

endmodule : resource_map_decoder

/* File: verif/ext_bus_model.sv */
`timescale 1ns/1ps

// External bus memory: once started, a bus cycle stays busy for CYCLES clocks.
module ext_bus_model #(
   parameter int CYCLES = 5
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Start from the bench, shutdown from the device.
   input wire logic start,
   input wire logic shutdown,
   // Bus cycle in progress.
   output logic busy
);
   logic [7:0] cnt_q;

   // A shut-down bus accepts no new cycle, so a late start cannot hide the shutdown.
   always_ff @(posedge clk) begin
      if (rst)
         cnt_q <= 8'h00;
      else if (start && !shutdown)
         cnt_q <= 8'(CYCLES);
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
   end

   assign busy = (cnt_q != 8'h00);
endmodule : ext_bus_model

/* File: verif/tb_resource_map_decoder.sv */
`timescale 1ns/1ps

module tb_resource_map_decoder;
   import map_pkg::*;
   typedef struct packed {logic [15:0] addr; logic dbg; logic [2:0] page; logic [5:0] sel; logic [1:0] arr;} row_s;
   typedef struct packed {logic s; logic b; logic a; logic k; logic e;} mode_s;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, special_mode_select_n, mode_b, mode_a;
   logic wait_mode, ext_bus_busy, debug_rom_active, sel_debug_rom, sel_regs, sel_ram, sel_eeprom;
   logic sel_flash, sel_external, k_port_mapped, e_port_mapped, k_port_gpio, ext_bus_shutdown;
   logic map_if_shutdown, ext_start;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] cpu_addr;
   logic [2:0] flash_page;
   logic [1:0] flash_array;
   logic [14:0] flash_offset;
   logic [5:0] sel_vec;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   int n;
   // Selects after reset in a normal expanded mode: regs 0x0000, EEPROM 0x0800, RAM 0x2000.
   row_s rows [14] = '{
      '{16'h0000, 1'b0, 3'h0, 6'h10, 2'h0}, '{16'h03ff, 1'b0, 3'h0, 6'h10, 2'h0},
      '{16'h0400, 1'b0, 3'h0, 6'h01, 2'h0}, '{16'h0800, 1'b0, 3'h0, 6'h04, 2'h0},
      '{16'h1000, 1'b0, 3'h0, 6'h01, 2'h0}, '{16'h2000, 1'b0, 3'h0, 6'h08, 2'h0},
      '{16'h3fff, 1'b0, 3'h0, 6'h08, 2'h0}, '{16'h4000, 1'b0, 3'h0, 6'h02, 2'h3},
      '{16'hc000, 1'b0, 3'h0, 6'h02, 2'h3}, '{16'h8000, 1'b0, 3'h2, 6'h02, 2'h1},
      '{16'h8000, 1'b0, 3'h6, 6'h02, 2'h3}, '{16'hff10, 1'b1, 3'h0, 6'h20, 2'h0},
      '{16'hff10, 1'b0, 3'h0, 6'h02, 2'h3}, '{16'h0009, 1'b0, 3'h0, 6'h10, 2'h0}};
   // Port mapping straight out of reset; the special expanded row stays last.
   mode_s modes [4] = '{'{1'b0, 1'b0, 1'b0, 1'b1, 1'b1}, '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
      '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1}, '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0}};

   assign sel_vec = {sel_debug_rom, sel_regs, sel_ram, sel_eeprom, sel_flash, sel_external};

   resource_map_decoder DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .special_mode_select_n(special_mode_select_n), .mode_b(mode_b), .mode_a(mode_a),
      .wait_mode(wait_mode), .ext_bus_busy(ext_bus_busy), .debug_rom_active(debug_rom_active),
      .cpu_addr(cpu_addr), .flash_page(flash_page), .sel_debug_rom(sel_debug_rom), .sel_regs(sel_regs),
      .sel_ram(sel_ram), .sel_eeprom(sel_eeprom), .sel_flash(sel_flash), .sel_external(sel_external),
      .flash_array(flash_array), .flash_offset(flash_offset), .k_port_mapped(k_port_mapped),
      .e_port_mapped(e_port_mapped), .k_port_gpio(k_port_gpio), .ext_bus_shutdown(ext_bus_shutdown),
      .map_if_shutdown(map_if_shutdown));

   ext_bus_model #(.CYCLES(5)) partner (.clk(clk), .rst(rst), .start(ext_start),
      .shutdown(ext_bus_shutdown), .busy(ext_bus_busy));

   // ----------------------------------------
   // Helpers.
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // One Avalon access; it returns at the edge where waitrequest was seen low.
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [31:0] q);
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, wd};
      avs_write <= wr;
      avs_read <= !wr;
      // No local limit: a slave that never answers is caught by the bench timeout.
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   // Clock and hang guard; the whole run needs about 150 cycles.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial begin
      clk = 1'b0; rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
      avs_writedata = 32'h0; special_mode_select_n = 1'b1; mode_b = 1'b1; mode_a = 1'b1;
      wait_mode = 1'b0; debug_rom_active = 1'b0; cpu_addr = 16'h0; flash_page = 3'h0; ext_start = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk);
         cpu_addr <= rows[i].addr;
         debug_rom_active <= rows[i].dbg;
         flash_page <= rows[i].page;
         #1;
         check("select", 32'(rows[i].sel), 32'(sel_vec));
         if (rows[i].sel == 6'h02) check("flash array", 32'(rows[i].arr), 32'(flash_array));
         if (rows[i].sel == 6'h02) check("flash offset", 32'({(rows[i].addr[15:14] == 2'h2) ? rows[i].page[0] : rows[i].addr[15], rows[i].addr[13:0]}), 32'(flash_offset));
      end
      $display("test decode table done");
      bus(1'b0, IDX_REG_POS, 8'h00, rd);
      check("reg pos reset", 32'h0, rd);
      bus(1'b0, 6'h3f, 8'h00, rd);
      check("unmapped read", 32'h0, rd);
      // Move the block onto RAM; the new place must not act before the second cycle.
      @(posedge clk);
      cpu_addr <= 16'h2000;
      wait_mode <= 1'b1;
      bus(1'b1, IDX_REG_POS, 8'h21, rd);
      #1 check("old decode", 32'h08, 32'(sel_vec));
      @(posedge clk);
      #1 check("new decode", 32'h10, 32'(sel_vec));
      check("map shutdown", 32'h1, 32'(map_if_shutdown));
      bus(1'b1, IDX_REG_POS, 8'h40, rd);
      bus(1'b0, IDX_REG_POS, 8'h00, rd);
      check("reg pos once", 32'h20, rd);
      #1 check("map running", 32'h0, 32'(map_if_shutdown));
      @(posedge clk);
      cpu_addr <= 16'h2400;
      wait_mode <= 1'b0;
      #1 check("upper half", 32'h08, 32'(sel_vec));
      check("k mapped", 32'h1, 32'({k_port_mapped, k_port_gpio} == 2'b11));
      $display("test position done");
      // Port K data inside the moved block; once removed, the RAM below it answers.
      @(posedge clk);
      cpu_addr <= 16'h20fd;
      bus(1'b1, IDX_MODE_CTL, 8'h07, rd);
      #1 check("k e unmapped", 32'h0, 32'({k_port_mapped, e_port_mapped, k_port_gpio}));
      check("k emulated", 32'h08, 32'(sel_vec));
      bus(1'b0, IDX_MODE_CTL, 8'h00, rd);
      check("mode bits", 32'h7, 32'(rd[2:0]));
      // Start a bus cycle, enter wait while it runs, then count to shutdown.
      ext_start <= 1'b1;
      @(posedge clk);
      ext_start <= 1'b0;
      wait_mode <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ext_bus_busy !== 1'b0 && n < 50);
      // The first idle cycle ends at the edge above; the delay count and the output flop follow it.
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ext_bus_shutdown !== 1'b1 && n < 50);
      check("shutdown delay", 32'(EXT_STOP_CYCLES + 1), 32'(n));
      wait_mode <= 1'b0;
      @(posedge clk);
      #1 check("shutdown leave", 32'h0, 32'(ext_bus_shutdown));
      // Enter wait with the bus already idle; the delay must still run out first.
      @(posedge clk);
      wait_mode <= 1'b1;
      repeat (EXT_STOP_CYCLES) @(posedge clk);
      #1 check("stop not early", 32'h0, 32'(ext_bus_shutdown));
      @(posedge clk);
      wait_mode <= 1'b0;
      bus(1'b1, IDX_MODE_CTL, 8'h00, rd);
      bus(1'b0, IDX_MODE_CTL, 8'h00, rd);
      check("mode bits", 32'h3, 32'(rd[2:0]));
      wait_mode <= 1'b1;
      repeat (12) @(posedge clk);
      #1 check("bus kept", 32'h0, 32'(ext_bus_shutdown));
      @(posedge clk);
      wait_mode <= 1'b0;
      $display("test wait done");
      foreach (modes[i]) begin
         @(posedge clk);
         rst <= 1'b1;
         special_mode_select_n <= modes[i].s;
         mode_b <= modes[i].b;
         mode_a <= modes[i].a;
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk);
         #1 check("port map", 32'({modes[i].k, modes[i].e}), 32'({k_port_mapped, e_port_mapped}));
      end
      // Special expanded mode: first emulate write dropped, wait-stops locked, positions free.
      bus(1'b1, IDX_MODE_CTL, 8'h04, rd);
      bus(1'b0, IDX_MODE_CTL, 8'h00, rd);
      check("special first", 32'h3, 32'(rd[2:0]));
      bus(1'b1, IDX_MODE_CTL, 8'h04, rd);
      bus(1'b0, IDX_MODE_CTL, 8'h00, rd);
      check("special later", 32'h0, 32'(rd[2:0]));
      #1 check("k back", 32'h1, 32'(k_port_mapped));
      bus(1'b1, IDX_REG_POS, 8'h09, rd);
      bus(1'b1, IDX_REG_POS, 8'h11, rd);
      bus(1'b0, IDX_REG_POS, 8'h00, rd);
      check("special pos", 32'h10, rd);
      $display("test modes done");
      wrap_up();
   end
endmodule : tb_resource_map_decoder
